// ---- include/lmcr_defines.svh ----
// Offsets, field positions and reset values of the LCD mode control registers.
// Assumes inclusion by bare name from files that use the lmcr_ prefix.
`ifndef LMCR_DEFINES_SVH
`define LMCR_DEFINES_SVH

// Register indexes; byte address is four times the index
`define LMCR_IDX_PANEL 6'h00
`define LMCR_IDX_MODE1 6'h02
`define LMCR_IDX_MODE2 6'h03
`define LMCR_IDX_PINS 6'h04

// Readable bits per register
`define LMCR_MASK_MODE1 8'hFF
`define LMCR_MASK_MODE2 8'h8F
`define LMCR_MASK_PANEL 8'h07
`define LMCR_MASK_PINS 8'h0F

// Pixel depth and display control fields
`define LMCR_M1_BPP_HI 7
`define LMCR_M1_BPP_LO 6
`define LMCR_M1_HIPERF 5
`define LMCR_M1_CLKDIV 4
`define LMCR_M1_BLANK 3
`define LMCR_M1_FREP 2
`define LMCR_M1_HWINV 1
`define LMCR_M1_SWINV 0

// Table bypass and power control fields
`define LMCR_M2_BYPASS 7
`define LMCR_M2_PWROVR 3
`define LMCR_M2_HPSEN 2
`define LMCR_M2_SPS_HI 1
`define LMCR_M2_SPS_LO 0

// Panel configuration fields
`define LMCR_PC_TYPE 0
`define LMCR_PC_COLOR 1
`define LMCR_PC_ROT 2

// General pin fields
`define LMCR_PN_P0CFG 0
`define LMCR_PN_P0VAL 1
`define LMCR_PN_P4CFG 2
`define LMCR_PN_P4VAL 3

// Reset values
`define LMCR_RST_MODE1 8'h00
`define LMCR_RST_MODE2 8'h00
`define LMCR_RST_PANEL 3'h0
`define LMCR_RST_PINS 4'h0

// Software power save codes
`define LMCR_SPS_SAVE 2'h0
`define LMCR_SPS_NORMAL 2'h3

// Frame counter
`define LMCR_FRAME_MAX 18'h3_FFFF
`define LMCR_FRAME_ZERO 18'h0_0000

// Bus answers
`define LMCR_RESP_OKAY 2'h0
`define LMCR_RESP_SLVERR 2'h2

`endif

// ---- include/lmcr_pkg.sv ----
// Types of the LCD mode control register block.
// Assumes lmcr_defines.svh is compiled alongside.
package lmcr_pkg;

    typedef enum logic {
        LMCR_PWR_NORMAL = 1'b0,
        LMCR_PWR_SAVE = 1'b1
    } lmcr_power_type;

    typedef struct packed {
        logic [7:0] mode1;
        logic [7:0] mode2;
        logic [2:0] panelCfg;
        logic [3:0] pinCtl;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [1:0] rresp;
        logic [7:0] rdata;
        logic opPhase;
        logic pixEn;
        logic memEn;
        logic [2:0] memCnt;
        logic pin0S1;
        logic pin0S2;
        logic pin11S1;
        logic pin11S2;
        logic [7:0] pixStage;
        logic pixStageValid;
        logic [7:0] panelData;
        logic panelDataValid;
        logic [17:0] frameCnt;
        logic patternRestart;
        lmcr_power_type pwrMode;
        logic panelPower;
        logic panelSignalsOn;
        logic [3:0] pixel_depth_field;
    } lmcr_state_type;

endpackage

// ---- src/lmcr_mode_regs.sv ----
// Mode control registers of an LCD controller with clock enables and pixel path.
// Assumes a single clock from the input clock pin and an AXI4-Lite master.
`timescale 1ns/100ps
`default_nettype none
`include "lmcr_defines.svh"

// How it works
// - Depth code 00/01/10 gives 1/2/4 bpp; 11 gives 8 bpp in colour.
// - Without high performance, memory clock is pixel clock over 8/4/2/1.
// - With high performance and unrotated display, memory clock equals pixel clock at every depth.
// - High performance bit is ignored while rotated display is active.
// - Divide bit 0 uses input clock as operating clock; 1 halves it.
// - Unrotated, pixel clock is the operating clock.
// - Blank bit drives every panel data line low.
// - Frame repeat wraps the frame counter at maximum; otherwise no repeat.
// - Passive panel: bit eleven is invert input or general pin four.
// - Software invert bit selects inverse video.
// - Hardware invert enabled on a passive panel: pin decides, software bit ignored.
// - Inversion is applied after the lookup table.
// - Gray modes use green table unless bypass bit is set.
// - Colour modes always use the table.
// - Override forces panel power off and signals low in power save.
// - Power save enable turns pin zero into power save input.
// - Pin zero as general pin: input reads level, output drives value.
// - Power save input is active high.
// - Software power save code 00 saves, 11 is normal operation.
// - Panel type bit: 0 passive, 1 active matrix.
// - Colour select bit: 0 monochrome, 1 colour.
module lmcr_mode_regs #(
    parameter int ADDR_W = 8,
    // Last count before wrap; lowered only to make wrap reachable in tests
    parameter logic [17:0] FRAME_LAST = `LMCR_FRAME_MAX
) (
    input wire logic clk,
    input wire logic rst,
    input wire logic [ADDR_W-1:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [ADDR_W-1:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [7:0] pixData,
    input wire logic pixValid,
    output logic pixReady,
    output logic [7:0] lutAddr,
    input wire logic [7:0] lutData,
    output logic [7:0] panelDataLines,
    output logic panelDataValid,
    input wire logic frameStart,
    output logic [17:0] frameCount,
    output logic patternRestart,
    output logic pixelClockEn,
    output logic memoryClockEn,
    output logic [3:0] bitsPerPixel,
    input wire logic seqPowerOn,
    input wire logic seqSignalsOn,
    output logic panelPowerOutput,
    output logic panelSignalsOn,
    output logic powerSaveActive,
    input wire logic generalPinZeroIn,
    output logic generalPinZeroOut,
    output logic generalPinZeroOe,
    input wire logic panelDataBitElevenIn,
    output logic generalPinFourOut,
    output logic generalPinFourOe
);

    lmcr_pkg::lmcr_state_type s_q;
    lmcr_pkg::lmcr_state_type s_d;

    logic wrGo;
    logic rdGo;
    logic [5:0] wrIdx;
    logic [5:0] rdIdx;
    logic passive;
    logic colour;
    logic rotated;
    logic [3:0] depth;
    logic [2:0] nextMask;
    logic hwInvActive;
    logic invertNow;
    logic useLut;
    logic forceOff;
    logic [7:0] pixOut;

    function automatic logic [3:0] depthBits(input logic [1:0] code, input logic col);
        logic [3:0] bits;
        bits = 4'h4;
        unique case (code)
            2'h0: bits = 4'h1;
            2'h1: bits = 4'h2;
            2'h2: bits = 4'h4;
            2'h3: bits = col ? 4'h8 : 4'h4;
        endcase
        return bits;
    endfunction

    function automatic logic [2:0] divMask(input logic [3:0] bits);
        logic [2:0] m;
        m = 3'h0;
        unique case (bits)
            4'h1: m = 3'h7;
            4'h2: m = 3'h3;
            4'h4: m = 3'h1;
            default: m = 3'h0;
        endcase
        return m;
    endfunction

    function automatic logic [7:0] depthMask(input logic [3:0] bits);
        return 8'(({4'h0, bits} == 8'h08) ? 8'hFF : ((8'h01 << bits) - 8'h01));
    endfunction

    function automatic logic [7:0] readReg(input logic [5:0] idx,
                                           input lmcr_pkg::lmcr_state_type s);
        logic [7:0] v;
        logic p0;
        logic p4;
        v = 8'h00;
        p0 = s.pinCtl[`LMCR_PN_P0CFG] ? s.pinCtl[`LMCR_PN_P0VAL] : s.pin0S2;
        p4 = s.pinCtl[`LMCR_PN_P4CFG] ? s.pinCtl[`LMCR_PN_P4VAL] : s.pin11S2;
        case (idx)
            `LMCR_IDX_MODE1: v = s.mode1 & `LMCR_MASK_MODE1;
            `LMCR_IDX_MODE2: v = s.mode2 & `LMCR_MASK_MODE2;
            `LMCR_IDX_PANEL: v = {5'h00, s.panelCfg} & `LMCR_MASK_PANEL;
            `LMCR_IDX_PINS: begin
                v = {4'h0, p4, s.pinCtl[`LMCR_PN_P4CFG], p0, s.pinCtl[`LMCR_PN_P0CFG]};
                v = v & `LMCR_MASK_PINS;
            end
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    function automatic logic regHit(input logic [5:0] idx);
        return idx == `LMCR_IDX_MODE1 || idx == `LMCR_IDX_MODE2 ||
               idx == `LMCR_IDX_PANEL || idx == `LMCR_IDX_PINS;
    endfunction

    // Write address and data are taken together, one response outstanding
    assign wrGo = s_axi_awvalid && s_axi_wvalid && !s_q.bvalid;
    assign rdGo = s_axi_arvalid && !s_q.rvalid;
    assign wrIdx = s_axi_awaddr[7:2];
    assign rdIdx = s_axi_araddr[7:2];
    assign s_axi_awready = wrGo;
    assign s_axi_wready = wrGo;
    assign s_axi_arready = !s_q.rvalid;

    assign passive = !s_q.panelCfg[`LMCR_PC_TYPE];
    assign colour = s_q.panelCfg[`LMCR_PC_COLOR];
    assign rotated = s_q.panelCfg[`LMCR_PC_ROT];
    assign depth = depthBits(s_q.mode1[`LMCR_M1_BPP_HI:`LMCR_M1_BPP_LO], colour);
    // High performance only counts unrotated
    assign nextMask = (s_q.mode1[`LMCR_M1_HIPERF] && !rotated) ? 3'h0 : divMask(depth);
    assign hwInvActive = passive && s_q.mode1[`LMCR_M1_HWINV];
    assign invertNow = hwInvActive ? s_q.pin11S2 : s_q.mode1[`LMCR_M1_SWINV];
    assign useLut = colour || !s_q.mode2[`LMCR_M2_BYPASS];
    assign forceOff = s_q.mode2[`LMCR_M2_PWROVR] && s_q.pwrMode == lmcr_pkg::LMCR_PWR_SAVE;
    // Invert after the table, then trim to the active depth
    assign pixOut = ((useLut ? lutData : s_q.pixStage) ^ {8{invertNow}}) & depthMask(depth);

    always_comb begin
        logic [1:0] sps;
        sps = s_q.mode2[`LMCR_M2_SPS_HI:`LMCR_M2_SPS_LO];
        s_d = s_q;
        s_d.pin0S1 = generalPinZeroIn;
        s_d.pin0S2 = s_q.pin0S1;
        s_d.pin11S1 = panelDataBitElevenIn;
        s_d.pin11S2 = s_q.pin11S1;
        s_d.pixel_depth_field = depth;

        if (wrGo) begin
            s_d.bvalid = 1'b1;
            s_d.bresp = regHit(wrIdx) ? `LMCR_RESP_OKAY : `LMCR_RESP_SLVERR;
            if (s_axi_wstrb[0]) begin
                case (wrIdx)
                    `LMCR_IDX_MODE1: s_d.mode1 = s_axi_wdata[7:0] & `LMCR_MASK_MODE1;
                    `LMCR_IDX_MODE2: s_d.mode2 = s_axi_wdata[7:0] & `LMCR_MASK_MODE2;
                    `LMCR_IDX_PANEL: s_d.panelCfg = s_axi_wdata[2:0];
                    `LMCR_IDX_PINS: s_d.pinCtl = s_axi_wdata[3:0];
                    default: s_d.mode1 = s_q.mode1;
                endcase
            end
        end else if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
        end

        if (rdGo) begin
            s_d.rvalid = 1'b1;
            s_d.rresp = regHit(rdIdx) ? `LMCR_RESP_OKAY : `LMCR_RESP_SLVERR;
            s_d.rdata = readReg(rdIdx, s_q);
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end

        // Operating clock enable: every cycle, or every other one when halved
        s_d.opPhase = s_q.mode1[`LMCR_M1_CLKDIV] ? !s_q.opPhase : 1'b0;
        s_d.pixEn = !s_q.mode1[`LMCR_M1_CLKDIV] || s_q.opPhase;

        // New ratio is loaded only at wrap, so no short or long memory pulse
        s_d.memEn = 1'b0;
        if (s_q.pixEn) begin
            if (s_q.memCnt == 3'h0) begin
                s_d.memEn = 1'b1;
                s_d.memCnt = nextMask;
            end else begin
                s_d.memCnt = s_q.memCnt - 3'h1;
            end
        end

        s_d.patternRestart = 1'b0;
        if (frameStart) begin
            if (s_q.frameCnt != FRAME_LAST) begin
                s_d.frameCnt = s_q.frameCnt + 18'h0_0001;
            end else if (s_q.mode1[`LMCR_M1_FREP]) begin
                s_d.frameCnt = `LMCR_FRAME_ZERO;
                s_d.patternRestart = 1'b1;
            end
        end

        if (s_q.pixEn) begin
            s_d.pixStageValid = pixValid;
            if (pixValid) begin
                s_d.pixStage = pixData;
            end
            s_d.panelDataValid = s_q.pixStageValid;
            if (s_q.pixStageValid) begin
                s_d.panelData = pixOut;
            end
        end
        // Blank and forced-off hold the lines low at once
        if (s_q.mode1[`LMCR_M1_BLANK] || forceOff || !s_q.panelSignalsOn) begin
            s_d.panelData = 8'h00;
        end

        if ((s_q.mode2[`LMCR_M2_HPSEN] && s_q.pin0S2) || sps == `LMCR_SPS_SAVE) begin
            s_d.pwrMode = lmcr_pkg::LMCR_PWR_SAVE;
        end else if (sps == `LMCR_SPS_NORMAL) begin
            s_d.pwrMode = lmcr_pkg::LMCR_PWR_NORMAL;
        end
        s_d.panelPower = !forceOff && seqPowerOn;
        s_d.panelSignalsOn = !forceOff && seqSignalsOn;
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            s_q <= '{mode1: `LMCR_RST_MODE1, mode2: `LMCR_RST_MODE2,
                     panelCfg: `LMCR_RST_PANEL, pinCtl: `LMCR_RST_PINS,
                     bresp: `LMCR_RESP_OKAY, rresp: `LMCR_RESP_OKAY,
                     frameCnt: `LMCR_FRAME_ZERO, pwrMode: lmcr_pkg::LMCR_PWR_SAVE,
                     pixel_depth_field: 4'h1, default: '0};
        end else begin
            s_q <= s_d;
        end
    end

    assign s_axi_bvalid = s_q.bvalid;
    assign s_axi_bresp = s_q.bresp;
    assign s_axi_rvalid = s_q.rvalid;
    assign s_axi_rresp = s_q.rresp;
    assign s_axi_rdata = {24'h00_0000, s_q.rdata};
    assign pixReady = s_q.pixEn;
    assign lutAddr = s_q.pixStage;
    assign panelDataLines = s_q.panelData;
    assign panelDataValid = s_q.panelDataValid;
    assign frameCount = s_q.frameCnt;
    assign patternRestart = s_q.patternRestart;
    assign pixelClockEn = s_q.pixEn;
    assign memoryClockEn = s_q.memEn;
    assign bitsPerPixel = s_q.pixel_depth_field;
    assign panelPowerOutput = s_q.panelPower;
    assign panelSignalsOn = s_q.panelSignalsOn;
    assign powerSaveActive = s_q.pwrMode == lmcr_pkg::LMCR_PWR_SAVE;
    // Pin zero drives only as a general output pin
    assign generalPinZeroOe = !s_q.mode2[`LMCR_M2_HPSEN] && s_q.pinCtl[`LMCR_PN_P0CFG];
    assign generalPinZeroOut = s_q.pinCtl[`LMCR_PN_P0VAL];
    assign generalPinFourOe = passive && !s_q.mode1[`LMCR_M1_HWINV] &&
                              s_q.pinCtl[`LMCR_PN_P4CFG];
    assign generalPinFourOut = s_q.pinCtl[`LMCR_PN_P4VAL];

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    property p_blank;
        s_q.mode1[`LMCR_M1_BLANK] |=> s_q.panelData == 8'h00;
    endproperty
    a_blank: assert property (p_blank) else $error("blank lines not low");

    property p_mem_ratio;
        s_q.pixEn && s_q.memCnt == 3'h0 |=> s_q.memEn && s_q.memCnt == $past(nextMask);
    endproperty
    a_mem_ratio: assert property (p_mem_ratio) else $error("memory divider reload wrong");

    property p_hiperf;
        s_q.pixEn && s_q.memCnt == 3'h0 && s_q.mode1[`LMCR_M1_HIPERF] && !rotated
            |=> s_q.memCnt == 3'h0;
    endproperty
    a_hiperf: assert property (p_hiperf) else $error("high performance not full rate");

    property p_halved;
        s_q.mode1[`LMCR_M1_CLKDIV] && $past(s_q.mode1[`LMCR_M1_CLKDIV]) && s_q.pixEn
            |=> !s_q.pixEn;
    endproperty
    a_halved: assert property (p_halved) else $error("halved clock enable too fast");

    property p_direct;
        !s_q.mode1[`LMCR_M1_CLKDIV] |=> s_q.pixEn;
    endproperty
    a_direct: assert property (p_direct) else $error("direct clock enable missing");

    property p_frame_wrap;
        frameStart && s_q.mode1[`LMCR_M1_FREP] && s_q.frameCnt == FRAME_LAST
            |=> s_q.frameCnt == `LMCR_FRAME_ZERO && s_q.patternRestart;
    endproperty
    a_frame_wrap: assert property (p_frame_wrap) else $error("frame counter did not wrap");

    property p_frame_hold;
        frameStart && !s_q.mode1[`LMCR_M1_FREP] && s_q.frameCnt == FRAME_LAST
            |=> s_q.frameCnt == FRAME_LAST && !s_q.patternRestart;
    endproperty
    a_frame_hold: assert property (p_frame_hold) else $error("pattern repeated");

    property p_invert_lut;
        s_q.pixEn && s_q.pixStageValid && useLut && !s_q.mode1[`LMCR_M1_BLANK] &&
            !forceOff && s_q.panelSignalsOn
            |=> s_q.panelData == (($past(lutData) ^ {8{$past(invertNow)}}) &
                depthMask($past(depth)));
    endproperty
    a_invert_lut: assert property (p_invert_lut) else $error("table or invert order wrong");

    property p_force_off;
        forceOff |=> !s_q.panelPower && s_q.panelData == 8'h00;
    endproperty
    a_force_off: assert property (p_force_off) else $error("override did not force off");

    property p_hw_save;
        s_q.mode2[`LMCR_M2_HPSEN] && s_q.pin0S2 |=> powerSaveActive;
    endproperty
    a_hw_save: assert property (p_hw_save) else $error("power save input ignored");

    property p_pin0_input;
        s_q.mode2[`LMCR_M2_HPSEN] |-> !generalPinZeroOe;
    endproperty
    a_pin0_input: assert property (p_pin0_input) else $error("pin zero driven as input");

    property p_readback;
        rdGo && rdIdx == `LMCR_IDX_MODE1 |=> s_axi_rvalid && s_axi_rdata == {24'h00_0000, $past(s_q.mode1)};
    endproperty
    a_readback: assert property (p_readback) else $error("mode read mismatch");

    c_write: cover property (wrGo && wrIdx == `LMCR_IDX_MODE1);
    c_restart: cover property (s_q.patternRestart);
    c_force: cover property (forceOff ##1 !forceOff);
    c_hold: cover property (frameStart && s_q.frameCnt == FRAME_LAST && !s_q.mode1[`LMCR_M1_FREP]);

endmodule
`default_nettype wire

// ---- verification/lmcr_panel_model.sv ----
// Far side of the pixel path: the lookup table that the panel data passes through.
// Assumes the block reads the table without a clock, in the cycle it drives the index.
`timescale 1ns/100ps
`default_nettype none
module lmcr_panel_model (
    input wire logic [7:0] lutAddr,
    output logic [7:0] lutData
);
    // Offset, not inversion, so inverting before or after the table differs
    assign lutData = lutAddr + 8'h11;
endmodule
`default_nettype wire

// ---- verification/tb_lcd_mode_control_regs.sv ----
// Self-checking bench for the LCD mode control registers, driven over AXI4-Lite.
// Assumes lmcr_defines.svh on the include path and the panel model compiled first.
`timescale 1ns/100ps
`default_nettype none
`include "lmcr_defines.svh"
module tb_lcd_mode_control_regs;
    typedef struct {
        logic [2:0] cfg;
        logic [7:0] m1;
        logic [7:0] m2;
        logic [3:0] pixel_depth_field;
        int pix;
        int mem;
        logic ps;
    } lmcr_row_type;
    typedef struct {
        logic [2:0] cfg;
        logic [7:0] m1;
        logic [7:0] m2;
        logic pin;
        logic [7:0] px;
        logic [7:0] exp;
    } lmcr_pix_type;
    // Negative pix skips counting; enables in power save are not specified
    lmcr_row_type rows[10] = '{
        '{3'h2, 8'h00, 8'h03, 4'h1, 64, 8, 1'b0}, '{3'h2, 8'h40, 8'hF3, 4'h2, 64, 16, 1'b0},
        '{3'h2, 8'h80, 8'h01, 4'h4, 64, 32, 1'b0}, '{3'h2, 8'hC0, 8'h00, 4'h8, -1, 0, 1'b1},
        '{3'h2, 8'h20, 8'h02, 4'h1, -1, 0, 1'b1}, '{3'h2, 8'h10, 8'h03, 4'h1, 32, 4, 1'b0},
        '{3'h2, 8'h30, 8'h03, 4'h1, 32, 32, 1'b0}, '{3'h0, 8'hC0, 8'h03, 4'h4, 64, 32, 1'b0},
        '{3'h2, 8'hC0, 8'h03, 4'h8, 64, 64, 1'b0}, '{3'h6, 8'h20, 8'h03, 4'h1, 64, 8, 1'b0}};
    lmcr_pix_type pxRows[8] = '{
        '{3'h2, 8'hC0, 8'h83, 1'b0, 8'h3C, 8'h4D}, '{3'h2, 8'hC1, 8'h83, 1'b0, 8'h3C, 8'hB2},
        '{3'h2, 8'hC3, 8'h83, 1'b0, 8'h3C, 8'h4D}, '{3'h2, 8'hC3, 8'h83, 1'b1, 8'h3C, 8'hB2},
        '{3'h2, 8'hC8, 8'h83, 1'b0, 8'h3C, 8'h00}, '{3'h2, 8'hC9, 8'h83, 1'b0, 8'h3C, 8'h00},
        '{3'h0, 8'h80, 8'h03, 1'b0, 8'h05, 8'h06}, '{3'h0, 8'h80, 8'h83, 1'b0, 8'h05, 8'h05}};
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, pixData = 8'h00, lutAddr, lutData, panelData;
    logic [31:0] wdata = 32'h0000_0000, rdata, np, nm, nr, rv;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic pixValid = 1'b0, frameStart = 1'b0, seqPowerOn = 1'b1, seqSignalsOn = 1'b1;
    logic pinZero = 1'b0, pinEleven = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, pixClkEn, memClkEn, panelPower, signalsOn;
    logic powerSave, pinZeroOut, pinZeroOe, pinFourOut, pinFourOe, restart, dataValid, pixRdy;
    logic [1:0] bresp, rresp, rsp;
    logic [3:0] bitsPerPixel;
    logic [17:0] frameCount, f0;
    int error_cnt = 0;
    int samples_checked = 0;
    int cyc = 0;

    initial begin
        forever #2 clk = ~clk;
    end

    // Short frame count so both wrap and hold are reachable
    lmcr_mode_regs #(.FRAME_LAST(18'h0_0007)) dut (.clk(clk), .rst(rst),
        .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .pixData(pixData), .pixValid(pixValid), .pixReady(pixRdy), .lutAddr(lutAddr),
        .lutData(lutData), .panelDataLines(panelData), .panelDataValid(dataValid),
        .frameStart(frameStart), .frameCount(frameCount), .patternRestart(restart),
        .pixelClockEn(pixClkEn), .memoryClockEn(memClkEn), .bitsPerPixel(bitsPerPixel),
        .seqPowerOn(seqPowerOn), .seqSignalsOn(seqSignalsOn), .panelPowerOutput(panelPower),
        .panelSignalsOn(signalsOn), .powerSaveActive(powerSave),
        .generalPinZeroIn(pinZero), .generalPinZeroOut(pinZeroOut),
        .generalPinZeroOe(pinZeroOe), .panelDataBitElevenIn(pinEleven),
        .generalPinFourOut(pinFourOut), .generalPinFourOe(pinFourOe));

    lmcr_panel_model model (.lutAddr(lutAddr), .lutData(lutData));

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic conclude();
        $display("checks=%0d mismatches=%0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    // Leading edge keeps a release and the next raise in separate steps
    task automatic wr(input logic [5:0] idx, input logic [7:0] val, output logic [1:0] resp);
        @(posedge clk);
        awaddr <= {idx, 2'b00};
        wdata <= {24'h00_0000, val};
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        @(posedge clk);
        while (awready !== 1'b1 || wready !== 1'b1) @(posedge clk);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        @(posedge clk);
        while (bvalid !== 1'b1) @(posedge clk);
        resp = bresp;
        bready <= 1'b0;
    endtask

    task automatic rd(input logic [5:0] idx, output logic [31:0] val, output logic [1:0] resp);
        @(posedge clk);
        araddr <= {idx, 2'b00};
        arvalid <= 1'b1;
        rready <= 1'b1;
        @(posedge clk);
        while (arready !== 1'b1) @(posedge clk);
        arvalid <= 1'b0;
        @(posedge clk);
        while (rvalid !== 1'b1) @(posedge clk);
        val = rdata;
        resp = rresp;
        rready <= 1'b0;
    endtask

    task automatic chkRd(input logic [5:0] idx, input logic [31:0] exp);
        logic [31:0] v;
        logic [1:0] r;
        rd(idx, v, r);
        check(v, exp);
        check(r, `LMCR_RESP_OKAY);
    endtask

    always @(posedge clk) begin
        cyc++;
        if (cyc == 12000) begin
            error_cnt++;
            conclude();
        end
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        chkRd(`LMCR_IDX_MODE1, 32'h0000_0000);
        chkRd(`LMCR_IDX_MODE2, 32'h0000_0000);
        check(powerSave, 1'b1);
        check(bitsPerPixel, 4'h1);
        $display("test reset done");
        foreach (rows[i]) begin
            wr(`LMCR_IDX_PANEL, {5'h00, rows[i].cfg}, rsp);
            wr(`LMCR_IDX_MODE1, rows[i].m1, rsp);
            wr(`LMCR_IDX_MODE2, rows[i].m2, rsp);
            repeat (24) @(posedge clk);
            chkRd(`LMCR_IDX_MODE1, {24'h00_0000, rows[i].m1});
            chkRd(`LMCR_IDX_MODE2, {24'h00_0000, rows[i].m2 & `LMCR_MASK_MODE2});
            check(bitsPerPixel, rows[i].pixel_depth_field);
            check(powerSave, rows[i].ps);
            if (rows[i].pix >= 0) begin
                np = 32'h0000_0000;
                nm = 32'h0000_0000;
                nr = 32'h0000_0000;
                repeat (64) begin
                    @(posedge clk);
                    np += pixClkEn;
                    nm += memClkEn;
                    nr += pixRdy;
                end
                check(np, rows[i].pix);
                check(nr, rows[i].pix);
                check(nm, rows[i].mem);
            end
        end
        $display("test mode rows done");
        wr(`LMCR_IDX_PINS, 8'h03, rsp);
        repeat (2) @(posedge clk);
        check({pinZeroOe, pinZeroOut}, 2'h3);
        wr(`LMCR_IDX_PINS, 8'h01, rsp);
        repeat (2) @(posedge clk);
        check({pinZeroOe, pinZeroOut}, 2'h2);
        pinZero <= 1'b1;
        wr(`LMCR_IDX_PINS, 8'h00, rsp);
        repeat (4) @(posedge clk);
        check(pinZeroOe, 1'b0);
        chkRd(`LMCR_IDX_PINS, 32'h0000_0002);
        check(powerSave, 1'b0);
        wr(`LMCR_IDX_MODE2, 8'h07, rsp);
        repeat (4) @(posedge clk);
        check(powerSave, 1'b1);
        pinZero <= 1'b0;
        repeat (4) @(posedge clk);
        check(powerSave, 1'b0);
        wr(`LMCR_IDX_PINS, 8'h0C, rsp);
        repeat (2) @(posedge clk);
        check({pinFourOe, pinFourOut}, 2'h3);
        wr(`LMCR_IDX_MODE1, 8'h22, rsp);
        repeat (2) @(posedge clk);
        check(pinFourOe, 1'b0);
        $display("test pins done");
        pixValid <= 1'b1;
        foreach (pxRows[i]) begin
            pixData <= pxRows[i].px;
            pinEleven <= pxRows[i].pin;
            wr(`LMCR_IDX_PANEL, {5'h00, pxRows[i].cfg}, rsp);
            wr(`LMCR_IDX_MODE1, pxRows[i].m1, rsp);
            wr(`LMCR_IDX_MODE2, pxRows[i].m2, rsp);
            repeat (12) @(posedge clk);
            check(panelData, pxRows[i].exp);
            check(dataValid, 1'b1);
        end
        $display("test pixel path done");
        wr(`LMCR_IDX_MODE2, 8'h0B, rsp);
        repeat (3) @(posedge clk);
        check({panelPower, signalsOn}, 2'h3);
        wr(`LMCR_IDX_MODE2, 8'h00, rsp);
        repeat (3) @(posedge clk);
        check(panelPower, 1'b1);
        seqPowerOn <= 1'b0;
        repeat (3) @(posedge clk);
        check(panelPower, 1'b0);
        seqPowerOn <= 1'b1;
        wr(`LMCR_IDX_MODE2, 8'h08, rsp);
        repeat (3) @(posedge clk);
        check({panelPower, signalsOn, panelData}, 10'h000);
        $display("test power done");
        f0 = frameCount;
        frameStart <= 1'b1;
        repeat (3) @(posedge clk);
        frameStart <= 1'b0;
        repeat (2) @(posedge clk);
        check(frameCount, f0 + 18'h0_0003);
        frameStart <= 1'b1;
        repeat (8) @(posedge clk);
        frameStart <= 1'b0;
        repeat (2) @(posedge clk);
        check(frameCount, 18'h0_0007);
        check(restart, 1'b0);
        wr(`LMCR_IDX_MODE1, 8'h84, rsp);
        frameStart <= 1'b1;
        @(posedge clk);
        frameStart <= 1'b0;
        @(posedge clk);
        check(restart, 1'b1);
        @(posedge clk);
        check({restart, frameCount}, 19'h0_0000);
        wr(6'h3F, 8'h55, rsp);
        check(rsp, `LMCR_RESP_SLVERR);
        rd(6'h3F, rv, rsp);
        check(rsp, `LMCR_RESP_SLVERR);
        $display("test frame and unmapped done");
        rst <= 1'b1;
        repeat (3) @(posedge clk);
        rst <= 1'b0;
        chkRd(`LMCR_IDX_MODE1, 32'h0000_0000);
        chkRd(`LMCR_IDX_MODE2, 32'h0000_0000);
        check(bitsPerPixel, 4'h1);
        check(powerSave, 1'b1);
        $display("test mid reset done");
        conclude();
    end
endmodule
`default_nettype wire
